// file: dv/dpgam_asserts.sv
module dpgam_asserts
  import dpgam_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic [1:0] i_spi_route,
  input wire logic [7:0] o_wide_pin_oe,
  input wire logic [2:0] o_narrow_pin_oe
);
  logic [7:0] alt_r, dir_r, alt_d_r, dir_d_r;
  // Delayed copy lines up with the second edge after a write, when pins change
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      alt_r <= RST_ALT;
      dir_r <= RST_DIR;
      alt_d_r <= RST_ALT;
      dir_d_r <= RST_DIR;
    end else begin
      if (i_sfr_wr && i_sfr_addr == ADDR_WIDE_ALT) alt_r <= i_sfr_wdata;
      if (i_sfr_wr && i_sfr_addr == ADDR_WIDE_DIR) dir_r <= i_sfr_wdata;
      alt_d_r <= alt_r;
      dir_d_r <= dir_r;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  a_reset_all_inputs:
    assert property ($rose(i_arst_n) |-> o_wide_pin_oe == 8'h00 && o_narrow_pin_oe == 3'h0)
    else $error("pin driven at reset release");
  a_boot_bit_gpio:
    assert property (o_wide_pin_oe[0] == ~dir_d_r[0]) else $error("boot pin direction wrong");
  a_alt_out_fixed:
    assert property ((alt_d_r & 8'h84 & ~o_wide_pin_oe) == 8'h00)
    else $error("alternate output not driven");
  a_alt_in_fixed:
    assert property ((alt_d_r & 8'h78 & o_wide_pin_oe) == 8'h00)
    else $error("alternate input driven");
  a_gpio_dir_bits:
    assert property (((o_wide_pin_oe ^ ~dir_d_r) & ~alt_d_r & 8'hfe) == 8'h00)
    else $error("gpio direction wrong");
  a_narrow_in_only:
    assert property (o_narrow_pin_oe[2] == 1'b0) else $error("input-only pin driven");
  a_spi_dirs_set:
    assert property (i_spi_route == SPI_ROUTE_PORT [*3] |-> o_narrow_pin_oe == 3'h3)
    else $error("serial port directions wrong");
  a_read_alt_sel:
    assert property (i_sfr_rd && !i_sfr_wr && i_sfr_addr == ADDR_WIDE_ALT |=> o_sfr_rdata == alt_r)
    else $error("select readback wrong");
  c_spi: cover property (i_spi_route == SPI_ROUTE_PORT [*3]);
  c_alt_all: cover property (alt_d_r == 8'hff);
  c_read: cover property (i_sfr_rd && i_sfr_addr == ADDR_WIDE_ALT);
endmodule // dpgam_asserts

bind dpgam_port_mux dpgam_asserts u_asserts (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
  .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
  .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata), .i_spi_route(i_spi_route),
  .o_wide_pin_oe(o_wide_pin_oe), .o_narrow_pin_oe(o_narrow_pin_oe));

// file: dv/dpgam_board.sv
module dpgam_board (
  input wire logic [7:0] i_wide_val,
  input wire logic [7:0] i_wide_oe,
  input wire logic [2:0] i_narrow_val,
  input wire logic [2:0] i_narrow_oe,
  input wire logic [7:0] i_ext_wide,
  input wire logic [2:0] i_ext_narrow,
  output logic [7:0] o_wide_lvl,
  output logic [2:0] o_narrow_lvl
);
  // Device-driven bits win; elsewhere the board's own drivers set the level
  assign o_wide_lvl = (i_wide_val & i_wide_oe) | (i_ext_wide & ~i_wide_oe);
  assign o_narrow_lvl = (i_narrow_val & i_narrow_oe) | (i_ext_narrow & ~i_narrow_oe);
endmodule // dpgam_board

// file: dv/dpgam_port_mux_tb.sv
module dpgam_port_mux_tb;
  import dpgam_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, arst_n, wr, rd, txd, pwm, sclk, smo, rxd, irq_a_n, irq_b_n, tm_a, tm_b, tm_c, smi;
  logic [7:0] addr, wdata, rdata, ow, oew, ext_w, w_lvl;
  logic [2:0] nar_o, nar_oe, ext_n, n_lvl;
  logic [1:0] route;
  logic rxo;
  int num_errors, total_checks, cycles;
  dpgam_port_mux DUT (.i_mclk(mclk), .i_arst_n(arst_n), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_wdata(wdata), .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_spi_route(route),
    .i_uart_txd(txd), .i_uart_rxd_out(rxo), .i_pwm_out(pwm), .i_serial_clk(sclk),
    .i_serial_master_out(smo), .i_wide_pin(w_lvl), .o_wide_pin(ow), .o_wide_pin_oe(oew),
    .i_narrow_pin(n_lvl), .o_narrow_pin(nar_o), .o_narrow_pin_oe(nar_oe), .o_uart_rxd(rxd),
    .o_ext_irq_a_low(irq_a_n), .o_ext_irq_b_low(irq_b_n), .o_timer_a_count_in(tm_a),
    .o_timer_b_count_in(tm_b), .o_timer_c_count_in(tm_c), .o_serial_master_in(smi));
  dpgam_board u_board (.i_wide_val(ow), .i_wide_oe(oew), .i_narrow_val(nar_o),
    .i_narrow_oe(nar_oe), .i_ext_wide(ext_w), .i_ext_narrow(ext_n), .o_wide_lvl(w_lvl),
    .o_narrow_lvl(n_lvl));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    check(rdata, exp);
  endtask
  // Pins follow a write two edges later; two spare edges keep clear of the update
  task automatic settle;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic t_reset_vals;
    rd_reg(ADDR_WIDE_DATA, 8'ha5);
    check(oew, 8'h00);
    check(ow, RST_DATA);
    check({6'h0, irq_b_n, irq_a_n}, 8'h03);
    rd_reg(ADDR_WIDE_DIR, RST_DIR);
    rd_reg(ADDR_WIDE_ALT, RST_ALT);
    rd_reg(ADDR_NARROW_DATA, 8'h06);
    rd_reg(8'h81, 8'h00);
  endtask
  task automatic t_gpio_out;
    wr_reg(ADDR_WIDE_DIR, 8'h00);
    wr_reg(ADDR_WIDE_DATA, 8'h3c);
    settle();
    check(oew, 8'hff);
    check(ow, 8'h3c);
    rd_reg(ADDR_WIDE_DATA, 8'h3c);
  endtask
  task automatic t_alt_sel;
    wr_reg(ADDR_WIDE_ALT, 8'hff);
    wr_reg(ADDR_WIDE_DIR, 8'hff);
    settle();
    check(oew, 8'h84);
    check({6'h0, ow[7], ow[2]}, {6'h0, pwm, txd});
    check({7'h0, rxd}, {7'h0, ext_w[1]});
    check({4'h0, irq_b_n, irq_a_n, tm_b, tm_a}, {4'h0, ext_w[4:3], ext_w[6:5]});
    wr_reg(ADDR_WIDE_DIR, 8'h00);
    settle();
    check(oew, 8'h87);
    check(ow & 8'h87, {pwm, 4'h0, txd, rxo, 1'b0});
    rd_reg(ADDR_WIDE_DATA, (8'h3c & 8'h87) | (8'ha5 & 8'h78));
  endtask
  task automatic t_spi;
    @(posedge mclk);
    route <= SPI_ROUTE_PORT;
    settle();
    check({5'h0, nar_oe}, 8'h03);
    check({5'h0, smi, nar_o[1:0]}, {5'h0, ext_n[2], smo, sclk});
    // Bit zero set to output: the timer select must still keep it an input
    wr_reg(ADDR_NARROW_DIR, 8'h00);
    route <= 2'h0;
    settle();
    check({5'h0, nar_oe}, 8'h02);
    check({7'h0, tm_c}, {7'h0, ext_n[0]});
  endtask
  initial begin
    arst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    route = 2'h0;
    txd = 1'b0;
    rxo = 1'b1;
    pwm = 1'b1;
    sclk = 1'b1;
    smo = 1'b0;
    ext_w = 8'ha5;
    ext_n = 3'h6;
    num_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset_vals();
    t_gpio_out();
    t_alt_sel();
    t_spi();
    stop_test();
  end
endmodule // dpgam_port_mux_tb

// file: verilog/dpgam_pin_cell.sv
// One bidirectional pin: chooses the drive and enable from role and registers
module dpgam_pin_cell
  import dpgam_pkg::*;
(
  input wire logic i_in_reset,
  input wire dpgam_role_t i_role,
  input wire logic i_dir,
  input wire logic i_latch,
  input wire logic i_alt_val,
  output logic o_out,
  output logic o_oe
);
  always_comb begin
    o_out = i_latch;
    o_oe = 1'b0;
    case (i_role)
      DPGAM_GPIO: o_oe = ~i_dir;
      DPGAM_ALT_OUT: begin
        o_out = i_alt_val;
        o_oe = 1'b1;
      end
      DPGAM_ALT_IN: o_oe = 1'b0;
      DPGAM_ALT_DIR: begin
        o_out = i_alt_val;
        o_oe = ~i_dir;
      end
      default: o_oe = 1'b0;
    endcase
    if (i_in_reset) begin
      o_oe = 1'b0;
    end
  end
endmodule // dpgam_pin_cell

// file: verilog/dpgam_pkg.sv
package dpgam_pkg;
  localparam int WIDE_W = 8;
  localparam int NARROW_W = 3;
  localparam logic [7:0] ADDR_WIDE_DATA = 8'h80;
  localparam logic [7:0] ADDR_NARROW_DATA = 8'h90;
  localparam logic [7:0] ADDR_WIDE_DIR = 8'h94;
  localparam logic [7:0] ADDR_WIDE_ALT = 8'h95;
  localparam logic [7:0] ADDR_NARROW_DIR = 8'h96;
  localparam logic [7:0] ADDR_NARROW_ALT = 8'h97;
  localparam logic [7:0] RST_DATA = 8'hff;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_ALT = 8'h00;
  localparam logic [1:0] SPI_ROUTE_PORT = 2'h1;
  // Wide port bit roles
  localparam int WB_BOOT = 0;
  localparam int WB_RXD = 1;
  localparam int WB_TXD = 2;
  localparam int WB_IRQA = 3;
  localparam int WB_IRQB = 4;
  localparam int WB_TMRA = 5;
  localparam int WB_TMRB = 6;
  localparam int WB_PWM = 7;
  // Narrow port bit roles
  localparam int NB_ZERO = 0;
  localparam int NB_ONE = 1;
  localparam int NB_IN = 2;
  typedef enum logic [1:0] {
    DPGAM_GPIO = 2'b00,
    DPGAM_ALT_OUT = 2'b01,
    DPGAM_ALT_IN = 2'b10,
    DPGAM_ALT_DIR = 2'b11
  } dpgam_role_t;
endpackage

// file: verilog/dpgam_port_mux.sv
// Summary of operation
// - One input pin, ten bidirectional GPIO pins
// - All pins inputs during reset
// - Alternate select outranks direction on wide port
// - Alternate selected: pin follows alternate function
// - Serial receive pin still follows its direction
// - Select clear: GPIO with register direction
// - Wide bit zero always GPIO, boot select
// - Direction 0 output, 1 input; reset ones
// - Wide port alternate function bit mapping
// - Fixed directions for alternate outputs and inputs
// - Narrow port: input-only bit2, timer, SPI routing
// - Wide data register eight bits, resets ones
// - Narrow port low three bits; SPI overrides
module dpgam_port_mux
  import dpgam_pkg::*;
#(
  parameter int WW = WIDE_W,
  parameter int NW = NARROW_W
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  input wire logic [1:0] i_spi_route,
  input wire logic i_uart_txd,
  input wire logic i_uart_rxd_out,
  input wire logic i_pwm_out,
  input wire logic i_serial_clk,
  input wire logic i_serial_master_out,
  input wire logic [WW-1:0] i_wide_pin,
  output logic [WW-1:0] o_wide_pin,
  output logic [WW-1:0] o_wide_pin_oe,
  input wire logic [NW-1:0] i_narrow_pin,
  output logic [NW-1:0] o_narrow_pin,
  output logic [NW-1:0] o_narrow_pin_oe,
  output logic o_uart_rxd,
  output logic o_ext_irq_a_low,
  output logic o_ext_irq_b_low,
  output logic o_timer_a_count_in,
  output logic o_timer_b_count_in,
  output logic o_timer_c_count_in,
  output logic o_serial_master_in
);
  typedef struct packed {
    logic [WW-1:0] wdata;
    logic [WW-1:0] wdir;
    logic [WW-1:0] walt;
    logic [NW-1:0] ndata;
    logic [NW-1:0] ndir;
    logic [NW-1:0] nalt;
    logic boot_done;
    logic [7:0] rdata;
    logic [WW-1:0] wout;
    logic [WW-1:0] woe;
    logic [NW-1:0] nout;
    logic [NW-1:0] noe;
    logic [6:0] fin;
  } dpgam_state_t;

  dpgam_state_t st_r;
  dpgam_state_t st_nxt;
  dpgam_role_t wrole [WW];
  dpgam_role_t nrole [NW];
  logic [WW-1:0] walt_val;
  logic [NW-1:0] nalt_val;
  logic [WW-1:0] cell_out;
  logic [WW-1:0] cell_oe;
  logic [NW-1:0] ncell_out;
  logic [NW-1:0] ncell_oe;
  logic spi_on;

  // Mix of pin level and latch, as a read presents it
  function automatic logic [7:0] port_view(input logic [7:0] pin, input logic [7:0] latch,
                                           input logic [7:0] oe);
    port_view = (pin & ~oe) | (latch & oe);
  endfunction

  assign spi_on = (i_spi_route == SPI_ROUTE_PORT);

  always_comb begin
    for (int k = 0; k < WW; k++) begin
      wrole[k] = DPGAM_GPIO;
      walt_val[k] = 1'b0;
    end
    // Bit zero never looks at its select bit
    if (st_r.walt[WB_RXD]) wrole[WB_RXD] = DPGAM_ALT_DIR;
    if (st_r.walt[WB_TXD]) wrole[WB_TXD] = DPGAM_ALT_OUT;
    if (st_r.walt[WB_IRQA]) wrole[WB_IRQA] = DPGAM_ALT_IN;
    if (st_r.walt[WB_IRQB]) wrole[WB_IRQB] = DPGAM_ALT_IN;
    if (st_r.walt[WB_TMRA]) wrole[WB_TMRA] = DPGAM_ALT_IN;
    if (st_r.walt[WB_TMRB]) wrole[WB_TMRB] = DPGAM_ALT_IN;
    if (st_r.walt[WB_PWM]) wrole[WB_PWM] = DPGAM_ALT_OUT;
    walt_val[WB_RXD] = i_uart_rxd_out;
    walt_val[WB_TXD] = i_uart_txd;
    walt_val[WB_PWM] = i_pwm_out;
    // wrole[WB_BOOT] stays GPIO regardless of select
  end

  always_comb begin
    for (int k = 0; k < NW; k++) begin
      nrole[k] = DPGAM_GPIO;
      nalt_val[k] = 1'b0;
    end
    nrole[NB_IN] = DPGAM_ALT_IN;
    if (spi_on) begin
      nrole[NB_ZERO] = DPGAM_ALT_OUT;
      nrole[NB_ONE] = DPGAM_ALT_OUT;
    end else if (st_r.walt[0]) begin
      // Narrow bit zero counts for the third timer, so it is an input
      nrole[NB_ZERO] = DPGAM_ALT_IN;
    end
    nalt_val[NB_ZERO] = i_serial_clk;
    nalt_val[NB_ONE] = i_serial_master_out;
  end

  genvar g;
  generate
    for (g = 0; g < WW; g++) begin : g_wide
      dpgam_pin_cell u_cell (
        .i_in_reset(~st_r.boot_done),
        .i_role(wrole[g]),
        .i_dir(st_r.wdir[g]),
        .i_latch(st_r.wdata[g]),
        .i_alt_val(walt_val[g]),
        .o_out(cell_out[g]),
        .o_oe(cell_oe[g])
      );
    end
    for (g = 0; g < NW; g++) begin : g_narrow
      dpgam_pin_cell u_cell (
        .i_in_reset(~st_r.boot_done),
        .i_role(nrole[g]),
        .i_dir(st_r.ndir[g]),
        .i_latch(st_r.ndata[g]),
        .i_alt_val(nalt_val[g]),
        .o_out(ncell_out[g]),
        .o_oe(ncell_oe[g])
      );
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    // One cycle after release before any pin may drive
    st_nxt.boot_done = 1'b1;
    st_nxt.wout = cell_out;
    st_nxt.woe = cell_oe;
    st_nxt.nout = ncell_out;
    st_nxt.noe = ncell_oe;
    // Interrupt samples idle high while unselected, so a low pin cannot raise a request
    st_nxt.fin = {i_narrow_pin[NB_IN], i_narrow_pin[NB_ZERO], i_wide_pin[WB_TMRB],
                  i_wide_pin[WB_TMRA],
                  i_wide_pin[WB_IRQB] | ~st_r.walt[WB_IRQB],
                  i_wide_pin[WB_IRQA] | ~st_r.walt[WB_IRQA],
                  i_wide_pin[WB_RXD]};
    if (i_sfr_wr) begin
      case (i_sfr_addr)
        ADDR_WIDE_DATA: st_nxt.wdata = i_sfr_wdata[WW-1:0];
        ADDR_WIDE_DIR: st_nxt.wdir = i_sfr_wdata[WW-1:0];
        ADDR_WIDE_ALT: st_nxt.walt = i_sfr_wdata[WW-1:0];
        ADDR_NARROW_DATA: st_nxt.ndata = i_sfr_wdata[NW-1:0];
        ADDR_NARROW_DIR: st_nxt.ndir = i_sfr_wdata[NW-1:0];
        ADDR_NARROW_ALT: st_nxt.nalt = i_sfr_wdata[NW-1:0];
        default: st_nxt.wdata = st_r.wdata;
      endcase
    end
    if (i_sfr_rd) begin
      case (i_sfr_addr)
        ADDR_WIDE_DATA: st_nxt.rdata = port_view(i_wide_pin, st_r.wdata, st_r.woe);
        ADDR_WIDE_DIR: st_nxt.rdata = st_r.wdir;
        ADDR_WIDE_ALT: st_nxt.rdata = st_r.walt;
        ADDR_NARROW_DATA: st_nxt.rdata = port_view({5'h00, i_narrow_pin},
                                                   {5'h00, st_r.ndata}, {5'h00, st_r.noe});
        ADDR_NARROW_DIR: st_nxt.rdata = {5'h00, st_r.ndir};
        ADDR_NARROW_ALT: st_nxt.rdata = {5'h00, st_r.nalt};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r.wdata <= RST_DATA;
      st_r.wdir <= RST_DIR;
      st_r.walt <= RST_ALT;
      st_r.ndata <= RST_DATA[2:0];
      st_r.ndir <= RST_DIR[2:0];
      st_r.nalt <= RST_ALT[2:0];
      st_r.boot_done <= 1'b0;
      st_r.rdata <= 8'h00;
      st_r.wout <= RST_DATA;
      st_r.woe <= 8'h00;
      st_r.nout <= RST_DATA[2:0];
      st_r.noe <= 3'h0;
      st_r.fin <= 7'h7f;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sfr_rdata = st_r.rdata;
  assign o_wide_pin = st_r.wout;
  assign o_wide_pin_oe = st_r.woe;
  assign o_narrow_pin = st_r.nout;
  assign o_narrow_pin_oe = st_r.noe;
  // Alternate inputs come from registered pin samples; only the two interrupts idle high when not selected
  assign o_uart_rxd = st_r.fin[0];
  assign o_ext_irq_a_low = st_r.fin[1];
  assign o_ext_irq_b_low = st_r.fin[2];
  assign o_timer_a_count_in = st_r.fin[3];
  assign o_timer_b_count_in = st_r.fin[4];
  assign o_timer_c_count_in = st_r.fin[5];
  assign o_serial_master_in = st_r.fin[6];
endmodule // dpgam_port_mux
